/* File: hw/sync_pkg.sv */
package sync_pkg;
  localparam int NUM_CH = 4;
  localparam int NUM_PIN = 7;
  localparam int SYNC_PIN_LO = 3;
  localparam int DLY_W = 24;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int PF_W = 2;
  localparam int PINF_W = PF_W * NUM_PIN;
  localparam int BANK_LSB = 4;
  localparam int IDX_LSB = 2;
  localparam int IDX_W = 2;

  // One clock; a microsecond tick paces every delay
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 8;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
  localparam int SYNC_PULSE_US = 10;
  localparam logic [DLY_W-1:0] SYNC_PULSE_TICKS =
    DLY_W'(SYNC_PULSE_US * TICK_NS / TICK_NS);
  localparam logic [DLY_W-1:0] DLY_ONE = 24'h00_0001;
  localparam logic [DLY_W-1:0] DLY_ZERO = 24'h00_0000;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_COUPLE = 8'h04;
  localparam logic [ADDR_W-1:0] REG_PINFUNC = 8'h08;
  localparam logic [ADDR_W-1:0] REG_OFFSET = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_MAXOFF = 8'h10;
  localparam logic [ADDR_W-1:0] REG_CMD = 8'h14;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] REG_RISE_BASE = 8'h20;
  localparam logic [ADDR_W-1:0] REG_FALL_BASE = 8'h30;

  // Field positions
  localparam int CTRL_SYNC_EN = 0;
  localparam int CTRL_KEY_COUP = 1;
  localparam int CMD_ON = 0;
  localparam int CMD_OFF = 1;
  localparam int CMD_CH_LSB = 4;
  localparam int STAT_CFG_ERR = 0;
  localparam int STAT_BUSY = 1;
  localparam int STAT_CH_LSB = 4;

  // Reset values
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [NUM_CH-1:0] COUPLE_RST = 4'h0;
  localparam logic [PINF_W-1:0] PINF_RST = 14'h0000;
  localparam logic [DLY_W-1:0] OFFSET_RST = 24'h00_0000;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

  typedef enum logic [PF_W-1:0] {
    PF_NONE, PF_ON_SYNC, PF_OFF_SYNC, PF_RSVD
  } pin_func_t;

  typedef enum logic [1:0] {CH_IDLE, CH_RISE, CH_FALL} ch_state_t;
endpackage

/* File: hw/ch_delay.sv */
module ch_delay (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Timing
  input wire logic tick_in,
  input wire logic [sync_pkg::DLY_W-1:0] rise_in,
  input wire logic [sync_pkg::DLY_W-1:0] fall_in,
  // Control
  input wire logic start_on_in,
  input wire logic start_off_in,
  output logic on_out
);
  import sync_pkg::*;

  ch_state_t state_q, state_d;
  logic [DLY_W-1:0] cnt_q, cnt_d;
  logic on_q, on_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    on_d = on_q;
    if (start_off_in) begin
      // Off beats a simultaneous on
      state_d = CH_FALL;
      cnt_d = fall_in;
    end else if (start_on_in) begin
      state_d = CH_RISE;
      cnt_d = rise_in;
    end else if (tick_in) begin
      unique case (state_q)
        CH_IDLE: begin
        end
        CH_RISE: begin
          if (cnt_q <= DLY_ONE) begin
            on_d = 1'b1;
            state_d = CH_IDLE;
          end else begin
            cnt_d = cnt_q - DLY_ONE;
          end
        end
        CH_FALL: begin
          if (cnt_q <= DLY_ONE) begin
            on_d = 1'b0;
            state_d = CH_IDLE;
          end else begin
            cnt_d = cnt_q - DLY_ONE;
          end
        end
        default: begin
          state_d = CH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_q <= CH_IDLE;
      cnt_q <= DLY_ZERO;
      on_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      on_q <= on_d;
    end
  end

  assign on_out = on_q;
endmodule

/* File: hw/cross_frame_output_sync.sv */
// Decided for this implementation: the Avalon-MM interface to the registers and the placing of the registers.
module cross_frame_output_sync (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  // Avalon-MM slave
  input wire logic [sync_pkg::ADDR_W-1:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [sync_pkg::DATA_W-1:0] AVS_WRITEDATA_IN,
  input wire logic [sync_pkg::BE_W-1:0] AVS_BYTEENABLE_IN,
  output logic [sync_pkg::DATA_W-1:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  // Front-panel on/off key
  input wire logic KEY_ON_IN,
  input wire logic KEY_OFF_IN,
  input wire logic [sync_pkg::NUM_CH-1:0] KEY_CH_IN,
  // Installed power modules
  input wire logic [sync_pkg::NUM_CH-1:0] MOD_PRESENT_IN,
  input wire logic [sync_pkg::NUM_CH*sync_pkg::DLY_W-1:0] MOD_OFFSET_IN,
  // Digital connector, open drain
  input wire logic [sync_pkg::NUM_PIN-1:0] DIG_PIN_IN,
  output logic [sync_pkg::NUM_PIN-1:0] DIG_PIN_OUT,
  output logic [sync_pkg::NUM_PIN-1:0] DIG_PIN_OE_OUT,
  // Channel outputs
  output logic [sync_pkg::NUM_CH-1:0] CH_ON_OUT
);
  import sync_pkg::*;

  function automatic logic [PF_W-1:0] pin_func(
      input logic [PINF_W-1:0] v, input int p);
    return v[PF_W*p +: PF_W];
  endfunction

  function automatic logic [NUM_PIN-1:0] pins_with(
      input logic [PINF_W-1:0] v, input pin_func_t f);
    logic [NUM_PIN-1:0] m;
    m = '0;
    for (int p = 0; p < NUM_PIN; p++) begin
      m[p] = (pin_func(v, p) == f);
    end
    return m;
  endfunction

  function automatic logic pin_cfg_ok(input logic [PINF_W-1:0] v);
    logic ok;
    logic [NUM_PIN-1:0] on_m;
    logic [NUM_PIN-1:0] off_m;
    ok = 1'b1;
    on_m = pins_with(v, PF_ON_SYNC);
    off_m = pins_with(v, PF_OFF_SYNC);
    for (int p = 0; p < NUM_PIN; p++) begin
      if (pin_func(v, p) == PF_RSVD) begin
        ok = 1'b0;
      end
      if (p < SYNC_PIN_LO && pin_func(v, p) != PF_NONE) begin
        ok = 1'b0;
      end
    end
    if ($countones(on_m) > 1 || $countones(off_m) > 1) begin
      ok = 1'b0;
    end
    return ok;
  endfunction

  function automatic logic in_bank(
      input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base);
    return a[ADDR_W-1:BANK_LSB] == base[ADDR_W-1:BANK_LSB];
  endfunction

  function automatic logic [DATA_W-1:0] be_merge(
      input logic [DATA_W-1:0] old, input logic [DATA_W-1:0] nv,
      input logic [BE_W-1:0] be);
    logic [DATA_W-1:0] r;
    r = old;
    for (int b = 0; b < BE_W; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nv[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Microsecond tick divider
  logic [TICK_W-1:0] div_q, div_d;
  logic tick_q, tick_d;

  always_comb begin
    tick_d = (div_q == TICK_LAST);
    div_d = tick_d ? '0 : div_q + 1'b1;
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  // Register file state
  logic wait_q, wait_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic [1:0] ctrl_q, ctrl_d;
  logic [NUM_CH-1:0] couple_q, couple_d;
  logic [PINF_W-1:0] pinf_q, pinf_d;
  logic [DLY_W-1:0] offset_q, offset_d;
  logic [DLY_W-1:0] rise_q [NUM_CH];
  logic [DLY_W-1:0] rise_d [NUM_CH];
  logic [DLY_W-1:0] fall_q [NUM_CH];
  logic [DLY_W-1:0] fall_d [NUM_CH];
  logic cfg_err_q, cfg_err_d;
  logic cmd_on_q, cmd_on_d;
  logic cmd_off_q, cmd_off_d;
  logic [NUM_CH-1:0] cmd_ch_q, cmd_ch_d;
  logic [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] wv;
  logic [DLY_W-1:0] max_ofs;
  logic [NUM_CH-1:0] ch_on;
  logic ofs_busy_q;
  logic [IDX_W-1:0] idx;

  assign idx = AVS_ADDRESS_IN[IDX_LSB +: IDX_W];

  // Slowest installed module, reported in microseconds
  always_comb begin
    max_ofs = DLY_ZERO;
    for (int i = 0; i < NUM_CH; i++) begin
      if (MOD_PRESENT_IN[i] && MOD_OFFSET_IN[DLY_W*i +: DLY_W] > max_ofs)
      begin
        max_ofs = MOD_OFFSET_IN[DLY_W*i +: DLY_W];
      end
    end
  end

  always_comb begin
    rd_word = WORD_ZERO;
    if (in_bank(AVS_ADDRESS_IN, REG_RISE_BASE)) begin
      rd_word[DLY_W-1:0] = rise_q[idx];
    end else if (in_bank(AVS_ADDRESS_IN, REG_FALL_BASE)) begin
      rd_word[DLY_W-1:0] = fall_q[idx];
    end else begin
      case (AVS_ADDRESS_IN)
        REG_CTRL: rd_word[1:0] = ctrl_q;
        REG_COUPLE: rd_word[NUM_CH-1:0] = couple_q;
        REG_PINFUNC: rd_word[PINF_W-1:0] = pinf_q;
        REG_OFFSET: rd_word[DLY_W-1:0] = offset_q;
        REG_MAXOFF: rd_word[DLY_W-1:0] = max_ofs;
        REG_STATUS: begin
          rd_word[STAT_CFG_ERR] = cfg_err_q;
          rd_word[STAT_BUSY] = ofs_busy_q;
          rd_word[STAT_CH_LSB +: NUM_CH] = ch_on;
        end
        default: rd_word = WORD_ZERO;
      endcase
    end
  end

  always_comb begin
    logic cfg_set;
    logic [DATA_W-1:0] w1c;
    cfg_set = 1'b0;
    w1c = be_merge(WORD_ZERO, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
    wait_d = 1'b1;
    rdata_d = rdata_q;
    ctrl_d = ctrl_q;
    couple_d = couple_q;
    pinf_d = pinf_q;
    offset_d = offset_q;
    rise_d = rise_q;
    fall_d = fall_q;
    cfg_err_d = cfg_err_q;
    cmd_on_d = 1'b0;
    cmd_off_d = 1'b0;
    cmd_ch_d = cmd_ch_q;
    wv = be_merge(rd_word, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
    // Every access waits one cycle, then is answered
    if ((AVS_READ_IN || AVS_WRITE_IN) && wait_q) begin
      wait_d = 1'b0;
      rdata_d = AVS_READ_IN ? rd_word : WORD_ZERO;
    end
    if (AVS_WRITE_IN && !wait_q) begin
      if (in_bank(AVS_ADDRESS_IN, REG_RISE_BASE)) begin
        rise_d[idx] = wv[DLY_W-1:0];
      end else if (in_bank(AVS_ADDRESS_IN, REG_FALL_BASE)) begin
        fall_d[idx] = wv[DLY_W-1:0];
      end else begin
        case (AVS_ADDRESS_IN)
          REG_CTRL: ctrl_d = wv[1:0];
          REG_COUPLE: couple_d = wv[NUM_CH-1:0];
          REG_PINFUNC: begin
            // Refused layouts leave the old map in place
            if (pin_cfg_ok(wv[PINF_W-1:0])) begin
              pinf_d = wv[PINF_W-1:0];
            end else begin
              cfg_set = 1'b1;
            end
          end
          REG_OFFSET: offset_d = wv[DLY_W-1:0];
          REG_CMD: begin
            cmd_on_d = w1c[CMD_ON];
            cmd_off_d = w1c[CMD_OFF];
            cmd_ch_d = w1c[CMD_CH_LSB +: NUM_CH];
          end
          REG_STATUS: begin
            if (w1c[STAT_CFG_ERR]) begin
              cfg_err_d = 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
    end
    if (cfg_set) begin
      cfg_err_d = 1'b1;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      wait_q <= 1'b1;
      rdata_q <= WORD_ZERO;
      ctrl_q <= CTRL_RST;
      couple_q <= COUPLE_RST;
      pinf_q <= PINF_RST;
      offset_q <= OFFSET_RST;
      for (int i = 0; i < NUM_CH; i++) begin
        rise_q[i] <= DLY_ZERO;
        fall_q[i] <= DLY_ZERO;
      end
      cfg_err_q <= 1'b0;
      cmd_on_q <= 1'b0;
      cmd_off_q <= 1'b0;
      cmd_ch_q <= '0;
    end else begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
      couple_q <= couple_d;
      pinf_q <= pinf_d;
      offset_q <= offset_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
      cfg_err_q <= cfg_err_d;
      cmd_on_q <= cmd_on_d;
      cmd_off_q <= cmd_off_d;
      cmd_ch_q <= cmd_ch_d;
    end
  end

  // Sync line state
  logic on_prev_q, on_prev_d;
  logic off_prev_q, off_prev_d;
  logic [DLY_W-1:0] on_drv_q, on_drv_d;
  logic [DLY_W-1:0] off_drv_q, off_drv_d;
  logic [NUM_PIN-1:0] oe_q, oe_d;
  logic ofs_busy_d;
  logic [DLY_W-1:0] ofs_cnt_q, ofs_cnt_d;
  logic [NUM_CH-1:0] grp_q, grp_d;
  logic [NUM_CH-1:0] xon_q, xon_d;
  logic [NUM_CH-1:0] xoff_q, xoff_d;
  logic [NUM_CH-1:0] start_on, start_off;

  always_comb begin
    logic [NUM_PIN-1:0] on_sel;
    logic [NUM_PIN-1:0] off_sel;
    logic on_line, off_line, on_fall, off_fall;
    logic req_on, req_off, hit;
    logic [NUM_CH-1:0] mask, loc_only, new_grp;
    on_sel = pins_with(pinf_q, PF_ON_SYNC);
    off_sel = pins_with(pinf_q, PF_OFF_SYNC);
    // Line use needs the enable and an assigned pin
    on_line = ctrl_q[CTRL_SYNC_EN] && (on_sel != '0);
    off_line = ctrl_q[CTRL_SYNC_EN] && (off_sel != '0);
    on_prev_d = |(on_sel & DIG_PIN_IN);
    off_prev_d = |(off_sel & DIG_PIN_IN);
    // Only a high-to-low step counts; no inversion option
    on_fall = on_line && on_prev_q && !on_prev_d;
    off_fall = off_line && off_prev_q && !off_prev_d;
    // Key and register commands share one path
    mask = (cmd_ch_q & {NUM_CH{cmd_on_q | cmd_off_q}}) |
           (KEY_CH_IN & {NUM_CH{KEY_ON_IN | KEY_OFF_IN}});
    req_off = cmd_off_q || KEY_OFF_IN;
    req_on = (cmd_on_q || KEY_ON_IN) && !req_off;
    hit = (mask & couple_q) != '0;
    loc_only = mask & ~couple_q;
    if (hit && ctrl_q[CTRL_KEY_COUP]) begin
      loc_only = ~couple_q;
    end
    on_drv_d = on_drv_q;
    off_drv_d = off_drv_q;
    xon_d = on_line ? xon_q : '0;
    xoff_d = off_line ? xoff_q : '0;
    start_off = '0;
    new_grp = '0;
    // Off path: no common offset
    if (req_off && hit && off_line) begin
      off_drv_d = SYNC_PULSE_TICKS;
      xoff_d = xoff_d | loc_only;
    end else if (req_off) begin
      start_off = (hit ? couple_q : '0) | loc_only;
    end
    if (off_fall) begin
      start_off = start_off | couple_q | xoff_q;
      xoff_d = '0;
    end
    // On path: everything funnels through the common offset
    if (req_on && hit && on_line) begin
      on_drv_d = SYNC_PULSE_TICKS;
      xon_d = xon_d | loc_only;
    end else if (req_on) begin
      new_grp = (hit ? couple_q : '0) | loc_only;
    end
    if (on_fall) begin
      new_grp = new_grp | couple_q | xon_q;
      xon_d = '0;
    end
    if (tick_q && on_drv_q != DLY_ZERO) begin
      on_drv_d = on_drv_q - DLY_ONE;
    end
    if (tick_q && off_drv_q != DLY_ZERO) begin
      off_drv_d = off_drv_q - DLY_ONE;
    end
    oe_d = (on_sel & {NUM_PIN{on_drv_d != DLY_ZERO}}) |
           (off_sel & {NUM_PIN{off_drv_d != DLY_ZERO}});
    start_on = '0;
    ofs_busy_d = ofs_busy_q;
    ofs_cnt_d = ofs_cnt_q;
    grp_d = grp_q;
    if (new_grp != '0) begin
      // A fresh event restarts the offset for the whole group
      ofs_busy_d = 1'b1;
      ofs_cnt_d = offset_q;
      grp_d = grp_q | new_grp;
    end else if (ofs_busy_q && tick_q) begin
      if (ofs_cnt_q <= DLY_ONE) begin
        start_on = grp_q;
        ofs_busy_d = 1'b0;
        grp_d = '0;
      end else begin
        ofs_cnt_d = ofs_cnt_q - DLY_ONE;
      end
    end
    // An off cancels the turn-on still waiting on the offset for each channel it switches off
    grp_d = grp_d & ~start_off;
    if (grp_d == '0) begin
      ofs_busy_d = 1'b0;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      on_prev_q <= 1'b0;
      off_prev_q <= 1'b0;
      on_drv_q <= DLY_ZERO;
      off_drv_q <= DLY_ZERO;
      oe_q <= '0;
      ofs_busy_q <= 1'b0;
      ofs_cnt_q <= DLY_ZERO;
      grp_q <= '0;
      xon_q <= '0;
      xoff_q <= '0;
    end else begin
      on_prev_q <= on_prev_d;
      off_prev_q <= off_prev_d;
      on_drv_q <= on_drv_d;
      off_drv_q <= off_drv_d;
      oe_q <= oe_d;
      ofs_busy_q <= ofs_busy_d;
      ofs_cnt_q <= ofs_cnt_d;
      grp_q <= grp_d;
      xon_q <= xon_d;
      xoff_q <= xoff_d;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      ch_delay u_ch (
        .clk_in(CLK_IN),
        .reset_in(RESET_IN),
        .tick_in(tick_q),
        .rise_in(rise_q[g]),
        .fall_in(fall_q[g]),
        .start_on_in(start_on[g]),
        .start_off_in(start_off[g]),
        .on_out(ch_on[g])
      );
    end
  endgenerate

  assign AVS_READDATA_OUT = rdata_q;
  assign AVS_WAITREQUEST_OUT = wait_q;
  // Open drain: the pin is only ever pulled low
  assign DIG_PIN_OUT = '0;
  assign DIG_PIN_OE_OUT = oe_q;
  assign CH_ON_OUT = ch_on;
endmodule

/* File: testbench/sync_chk.sv */
module sync_chk (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  // Bus and key
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic AVS_WAITREQUEST_OUT,
  input wire logic KEY_ON_IN,
  // Pins and channels
  input wire logic [sync_pkg::NUM_PIN-1:0] DIG_PIN_IN,
  input wire logic [sync_pkg::NUM_PIN-1:0] DIG_PIN_OUT,
  input wire logic [sync_pkg::NUM_PIN-1:0] DIG_PIN_OE_OUT,
  input wire logic [sync_pkg::NUM_CH-1:0] CH_ON_OUT
);
  import sync_pkg::*;
  logic [11:0] since_d;
  logic [11:0] since_q;
  logic [NUM_CH-1:0] ch_q;
  logic [NUM_PIN-1:0] pin_q;
  logic ev;
  // Any possible start of a turn-on restarts the count
  always_comb begin
    ev = KEY_ON_IN | AVS_WRITE_IN | (|(pin_q & ~DIG_PIN_IN));
    since_d = since_q + {11'h000, since_q != 12'hFFF};
    if (RESET_IN || ev) begin
      since_d = 12'h000;
    end
  end
  always_ff @(posedge CLK_IN) begin
    since_q <= since_d;
    ch_q <= CH_ON_OUT;
    pin_q <= DIG_PIN_IN;
  end
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);
  pin_drive_low_a: assert property (DIG_PIN_OUT == '0)
    else $error("sync pin driven high");
  low_pins_free_a: assert property (
    DIG_PIN_OE_OUT[SYNC_PIN_LO-1:0] == '0)
    else $error("pin 1 to 3 pulled");
  sync_pins_few_a: assert property (
    $countones(DIG_PIN_OE_OUT) <= 2)
    else $error("too many sync pins pulled");
  pulse_hold_a: assert property (
    $rose(|DIG_PIN_OE_OUT) |-> (|DIG_PIN_OE_OUT)[*8])
    else $error("sync pulse too short");
  oe_from_request_a: assert property (
    $rose(|DIG_PIN_OE_OUT) |-> since_q <= 12'd8)
    else $error("sync pulse without local request");
  on_after_offset_a: assert property (
    |(CH_ON_OUT & ~ch_q) |-> since_q >= 12'd200)
    else $error("channel on before offset");
  bus_answer_a: assert property (
    (AVS_READ_IN | AVS_WRITE_IN) && AVS_WAITREQUEST_OUT
    |=> !AVS_WAITREQUEST_OUT)
    else $error("access not answered");
  wait_single_a: assert property (
    !AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
    else $error("answer longer than one cycle");
  cover property ($rose(|DIG_PIN_OE_OUT));
  cover property (|(CH_ON_OUT & ~ch_q));
  cover property (|(~CH_ON_OUT & ch_q));
endmodule
bind cross_frame_output_sync sync_chk u_sync_chk (
  .CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .AVS_READ_IN(AVS_READ_IN),
  .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
  .KEY_ON_IN(KEY_ON_IN), .DIG_PIN_IN(DIG_PIN_IN),
  .DIG_PIN_OUT(DIG_PIN_OUT), .DIG_PIN_OE_OUT(DIG_PIN_OE_OUT),
  .CH_ON_OUT(CH_ON_OUT));

/* File: testbench/peer_frame.sv */
module peer_frame #(
  parameter int HOLD_CYC = 2500
) (
  input wire logic clk_in,
  input wire logic [1:0] trig_in,
  input wire logic [1:0] line_in,
  output logic [1:0] oe_out,
  output logic [7:0] seen_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt [2] = '{0, 0};
  logic [1:0] line_q = 2'h3;
  initial oe_out = 2'h0;
  initial seen_out = 8'h00;
  always @(posedge clk_in) begin
    for (int i = 0; i < 2; i++) begin
      // Pull low only, for the fixed pulse
      if (trig_in[i]) cnt[i] = HOLD_CYC;
      else if (cnt[i] > 0) cnt[i] = cnt[i] - 1;
      oe_out[i] <= cnt[i] > 0;
      // Any falling edge is an event, whoever pulled
      if (line_q[i] && !line_in[i]) begin
        seen_out[4*i+:4] <= seen_out[4*i+:4] + 4'h1;
      end
    end
    line_q <= line_in;
  end
endmodule

/* File: testbench/tb_cross_frame_output_sync.sv */
module tb_cross_frame_output_sync;
  timeunit 1ns;
  timeprecision 1ps;
  import sync_pkg::*;
  logic CLK_IN = 1'b0;
  logic RESET_IN = 1'b1;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic wreq;
  logic key_on = 1'b0;
  logic key_off = 1'b0;
  logic [3:0] key_ch = 4'h0;
  logic [3:0] present = 4'h7;
  // Largest module offset stays at or below the common offset used later
  logic [95:0] offs = {24'h00_0004, 24'h00_0002, 24'h00_0003, 24'h00_0001};
  logic [6:0] pin_out, oe, line;
  logic [3:0] ch_on;
  logic [1:0] ptrig = 2'h0;
  logic [1:0] poe;
  logic [7:0] seen;
  int fail_count = 0;
  int tests_run = 0;
  always #2 CLK_IN = ~CLK_IN;
  // Pull-up on every pin, any party may pull low
  assign line = ~(oe | {poe, 5'h00});
  cross_frame_output_sync u_cross_frame_output_sync (
    .CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .AVS_ADDRESS_IN(adr),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdat),
    .AVS_BYTEENABLE_IN(4'hF), .AVS_READDATA_OUT(rdat),
    .AVS_WAITREQUEST_OUT(wreq), .KEY_ON_IN(key_on), .KEY_OFF_IN(key_off),
    .KEY_CH_IN(key_ch), .MOD_PRESENT_IN(present), .MOD_OFFSET_IN(offs),
    .DIG_PIN_IN(line), .DIG_PIN_OUT(pin_out), .DIG_PIN_OE_OUT(oe),
    .CH_ON_OUT(ch_on));
  peer_frame u_peer_frame (.clk_in(CLK_IN), .trig_in(ptrig),
    .line_in(line[6:5]), .oe_out(poe), .seen_out(seen));
  task summarize;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task hang(input string nm);
    fail_count++;
    $display("Error %s expected done seen timeout", nm);
    summarize;
  endtask
  // Request held until waitrequest is sampled low
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] q);
    int n;
    @(posedge CLK_IN);
    adr <= a; wdat <= d; wr <= w; rd <= ~w;
    n = 0;
    do begin @(posedge CLK_IN); n++; end while (wreq !== 1'b0 && n < 50);
    q = rdat;
    wr <= 1'b0; rd <= 1'b0;
    if (wreq !== 1'b0) hang("bus");
  endtask
  task wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(nm, e, q);
  endtask
  task key(input logic off, input logic [3:0] m);
    @(posedge CLK_IN);
    key_ch <= m; key_on <= ~off; key_off <= off;
    @(posedge CLK_IN);
    key_on <= 1'b0; key_off <= 1'b0;
  endtask
  task peer(input logic [1:0] t);
    @(posedge CLK_IN); ptrig <= t;
    @(posedge CLK_IN); ptrig <= 2'h0;
  endtask
  task wait_ch(input logic [3:0] e, output int n);
    n = 0;
    while (ch_on !== e && n < 4000) begin @(posedge CLK_IN); n++; end
    if (ch_on !== e) hang("channels");
  endtask
  task idle;
    int n;
    n = 0;
    while ((oe | {poe, 5'h00}) !== 7'h00 && n < 4000) begin
      @(posedge CLK_IN); n++;
    end
    if (n >= 4000) hang("pins idle");
  endtask
  task t_regs;
    logic [7:0] a [7];
    a = '{REG_CTRL, REG_COUPLE, REG_PINFUNC, REG_OFFSET, REG_CMD,
          REG_STATUS, 8'h40};
    for (int i = 0; i < 7; i++) rchk("reset value", a[i], WORD_ZERO);
    wreg(8'h40, 32'hFFFF_FFFF);
    rchk("unmapped", 8'h40, WORD_ZERO);
    rchk("max offset", REG_MAXOFF, 32'h0000_0003);
    @(posedge CLK_IN); present <= 4'hF;
    rchk("max offset all", REG_MAXOFF, 32'h0000_0004);
    $display("test regs done");
  endtask
  task t_pins;
    logic [31:0] bad [3];
    bad = '{32'h0000_0010, 32'h0000_0140, 32'h0000_00C0};
    for (int i = 0; i < 3; i++) begin
      wreg(REG_PINFUNC, bad[i]);
      rchk("pin map kept", REG_PINFUNC, WORD_ZERO);
      rchk("cfg error", REG_STATUS, 32'h0000_0001);
      wreg(REG_STATUS, 32'h0000_0001);
    end
    wreg(REG_PINFUNC, 32'h0000_2400);
    rchk("pin map", REG_PINFUNC, 32'h0000_2400);
    $display("test pins done");
  endtask
  task t_local;
    int n, bad;
    wreg(REG_COUPLE, 32'h0000_0003);
    key(1'b0, 4'h1);
    bad = 0;
    for (n = 0; n < 600; n++) begin
      @(posedge CLK_IN);
      if (oe !== 7'h00) bad++;
    end
    chk("pin pulled while disabled", 0, bad);
    chk("local on while disabled", 32'h3, ch_on);
    key(1'b1, 4'hF);
    wait_ch(4'h0, n);
    $display("test local done");
  endtask
  task t_sync_on;
    int n;
    wreg(REG_OFFSET, 32'h0000_0004);
    wreg(REG_RISE_BASE, 32'h0000_0001);
    wreg(REG_RISE_BASE + 8'h04, 32'h0000_0003);
    wreg(REG_CTRL, 32'h0000_0001);
    key(1'b0, 4'h1);
    wait_ch(4'h1, n);
    chk("offset then rise", 1, n >= 990 && n <= 1280);
    wait_ch(4'h3, n);
    chk("coupled ch delay", 1, n >= 495 && n <= 505);
    chk("peer saw on edge", 32'h1, seen[3:0]);
    $display("test sync on done");
  endtask
  task t_peer_off;
    int n;
    idle;
    peer(2'h2);
    wait_ch(4'h0, n);
    chk("off without offset", 1, n <= 520);
    $display("test peer off done");
  endtask
  task t_cmd;
    int n;
    idle;
    wreg(REG_CMD, 32'h0000_0021);
    wait_ch(4'h3, n);
    chk("peer saw cmd edge", 32'h2, seen[3:0]);
    peer(2'h2);
    wait_ch(4'h0, n);
    $display("test cmd done");
  endtask
  task t_keycoup;
    int n;
    idle;
    wreg(REG_CTRL, 32'h0000_0003);
    key(1'b0, 4'h1);
    wait_ch(4'hF, n);
    chk("peer saw key edge", 32'h3, seen[3:0]);
    key(1'b1, 4'h1);
    wait_ch(4'h0, n);
    chk("peer saw off edges", 32'h3, seen[7:4]);
    $display("test key coupled done");
  endtask
  initial begin
    repeat (5) @(posedge CLK_IN);
    RESET_IN <= 1'b0;
    @(posedge CLK_IN);
    t_regs;
    t_pins;
    t_local;
    t_sync_on;
    t_peer_off;
    t_cmd;
    t_keycoup;
    summarize;
  end
endmodule
